// ---- logic/uclk_top.sv ----
// Function
// - usb module gets a 48 MHz clock when it is enabled in a primary pll mode.
// - oscillator prescaled to 4 MHz drives a 96 MHz pll feeding both branches.
// - usb branch divides the pll output by two.
// - system branch divides by three, then by a configurable postscaler.
// - branch divider codes 00..11 give 32, 16, 8, 4 MHz.
// - prescale codes 000..111 divide by 1,2,3,4,5,6,10,12.
// - usb clock only in primary pll modes; no external usb clock path.
// - enable bit 15 drives the divided reference onto its pin.
// - divisor 0000 passes base clock; code n divides by two to the n.
// - source bit 12 picks primary oscillator, else current system clock.
// - sleep-run bit 13 keeps output running in sleep, else stops it.
// - sleep output needs sleep-run, source, primary mode; keepalive powers osc.
// - reference output works in every oscillator mode while awake.
// - certain modes drive oscillator divided by two on a clock pin.
// - bit 14 and bits 7..0 read zero and ignore writes.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
module uclk_top
	import uclk_pkg::*;
#(
	parameter int REF_DIV_W = 4
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// clock sources, sampled as synchronous levels or ticks
	input  wire logic        posc_tick,
	input  wire logic        pll_out_tick,
	input  wire logic        posc_clk,
	input  wire logic        sys_clk,
	// power and usb context
	input  wire logic        sleep_active,
	input  wire logic        usb_module_en,
	// generated clocks and controls
	output logic             pll_ref_tick,
	output logic             usb_clk_tick,
	output logic             sys_clk_tick,
	output logic             usb_clk_valid,
	output logic             posc_power_en,
	output logic             half_rate_clock_out,
	output logic             refout_pin,
	output logic             refout_pin_oe_n
);

	initial begin
		if (REF_DIV_W != 4)
			$error("uclk_top: REF_DIV_W must be 4");
	end

	// ==========================================================
	// register bus slave
	// ==========================================================
	uclk_refcon_t ref_r, ref_nxt;
	logic [31:0]  cfg_r, cfg_nxt;
	logic         aw_have_r, aw_have_nxt;
	logic [3:0]   aw_addr_r, aw_addr_nxt;
	logic         aw_bad_r, aw_bad_nxt;
	logic         w_have_r, w_have_nxt;
	logic [31:0]  w_data_r, w_data_nxt;
	logic [3:0]   w_strb_r, w_strb_nxt;
	logic         bvalid_r, bvalid_nxt;
	logic [1:0]   bresp_r, bresp_nxt;
	logic         rvalid_r, rvalid_nxt;
	logic [31:0]  rdata_r, rdata_nxt;
	logic [1:0]   rresp_r, rresp_nxt;
	logic [31:0]  status_w;
	logic [31:0]  wmask;
	uclk_cfg_t    cfg;

	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready  = !w_have_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	assign cfg.pll_input_prescale    = cfg_r[UCLK_CFG_PRE_LSB +: 3];
	assign cfg.sys_clk_branch_div    = cfg_r[UCLK_CFG_CPD_LSB +: 2];
	assign cfg.osc_mode              = cfg_r[UCLK_CFG_MODE_LSB +: 3];
	assign cfg.primary_osc_keepalive = cfg_r[UCLK_CFG_KEEP_BIT];

	always_comb begin
		for (int i = 0; i < 4; i++)
			wmask[i*8 +: 8] = {8{w_strb_r[i]}};
	end

	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		aw_bad_nxt  = aw_bad_r;
		w_have_nxt  = w_have_r;
		w_data_nxt  = w_data_r;
		w_strb_nxt  = w_strb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		ref_nxt     = ref_r;
		cfg_nxt     = cfg_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr[3:0];
			aw_bad_nxt  = |s_axi_awaddr[31:4];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (aw_have_r && w_have_r) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = UCLK_RESP_OKAY;
			if (!aw_bad_r && aw_addr_r == UCLK_OFS_REFCON) begin
				// unimplemented bits never take a write
				ref_nxt = (ref_r & ~(wmask[15:0] & UCLK_REF_WMASK))
					| (w_data_r[15:0] & wmask[15:0]
					& UCLK_REF_WMASK);
			end else if (!aw_bad_r && aw_addr_r == UCLK_OFS_CONFIG) begin
				cfg_nxt = (cfg_r & ~(wmask & UCLK_CFG_WMASK))
					| (w_data_r & wmask & UCLK_CFG_WMASK);
			end else if (aw_bad_r || aw_addr_r != UCLK_OFS_STATUS) begin
				bresp_nxt = UCLK_RESP_SLVERR;
			end
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
	end

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = UCLK_RESP_OKAY;
			rdata_nxt  = 32'h0000_0000;
			if (|s_axi_araddr[31:4])
				rresp_nxt = UCLK_RESP_SLVERR;
			else if (s_axi_araddr[3:0] == UCLK_OFS_REFCON)
				rdata_nxt = {16'h0000, ref_r & UCLK_REF_WMASK};
			else if (s_axi_araddr[3:0] == UCLK_OFS_CONFIG)
				rdata_nxt = cfg_r;
			else if (s_axi_araddr[3:0] == UCLK_OFS_STATUS)
				rdata_nxt = status_w;
			else
				rresp_nxt = UCLK_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_r     <= UCLK_REF_RESET;
			cfg_r     <= UCLK_CFG_RESET;
			aw_have_r <= 1'b0;
			aw_addr_r <= 4'h0;
			aw_bad_r  <= 1'b0;
			w_have_r  <= 1'b0;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= UCLK_RESP_OKAY;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= UCLK_RESP_OKAY;
		end else begin
			ref_r     <= ref_nxt;
			cfg_r     <= cfg_nxt;
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			aw_bad_r  <= aw_bad_nxt;
			w_have_r  <= w_have_nxt;
			w_data_r  <= w_data_nxt;
			w_strb_r  <= w_strb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	// ==========================================================
	// usb pll branches
	// ==========================================================
	logic       primary_mode;
	logic       primary_pll_mode;
	logic [3:0] pre_div;
	logic [3:0] post_div;
	logic       sys_branch_tick;
	logic       usb_raw_tick;
	logic       usb_cfg_error;

	assign primary_pll_mode = cfg.osc_mode == UCLK_MODE_XT_PLL
		|| cfg.osc_mode == UCLK_MODE_HS_PLL
		|| cfg.osc_mode == UCLK_MODE_EC_PLL;
	assign primary_mode = primary_pll_mode
		|| cfg.osc_mode == UCLK_MODE_XT
		|| cfg.osc_mode == UCLK_MODE_HS
		|| cfg.osc_mode == UCLK_MODE_EC;

	always_comb begin
		case (cfg.pll_input_prescale)
			3'h0:    pre_div = 4'h1;
			3'h1:    pre_div = 4'h2;
			3'h2:    pre_div = 4'h3;
			3'h3:    pre_div = 4'h4;
			3'h4:    pre_div = 4'h5;
			3'h5:    pre_div = 4'h6;
			3'h6:    pre_div = 4'ha;
			default: pre_div = 4'hc;
		endcase
		case (cfg.sys_clk_branch_div)
			2'h0:    post_div = 4'h1;
			2'h1:    post_div = 4'h2;
			2'h2:    post_div = 4'h4;
			default: post_div = 4'h8;
		endcase
	end

	// prescaled oscillator is the 4 MHz pll reference
	uclk_div #(.W(4)) u_pre (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (posc_tick),
		.div      (pre_div),
		.tick_out (pll_ref_tick)
	);

	uclk_div #(.W(4)) u_usb (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (pll_out_tick),
		.div      (UCLK_USB_DIV),
		.tick_out (usb_raw_tick)
	);

	uclk_div #(.W(4)) u_sys3 (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (pll_out_tick),
		.div      (UCLK_SYS_DIV),
		.tick_out (sys_branch_tick)
	);

	uclk_div #(.W(4)) u_post (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (sys_branch_tick),
		.div      (post_div),
		.tick_out (sys_clk_tick)
	);

	// the usb clock exists only behind a primary pll mode; nothing else
	// may feed it
	assign usb_clk_valid = usb_module_en && primary_pll_mode;
	assign usb_clk_tick  = usb_raw_tick && usb_clk_valid;
	// flagged only; the slow codes are software's to avoid
	assign usb_cfg_error = usb_module_en && (!primary_pll_mode
		|| cfg.sys_clk_branch_div[1]);

	// ==========================================================
	// half-rate clock pin and primary oscillator power
	// ==========================================================
	logic half_r, half_nxt;
	logic half_mode;

	assign half_mode = cfg.osc_mode == UCLK_MODE_RC
		|| cfg.osc_mode == UCLK_MODE_RC_PLL;
	assign half_nxt  = half_mode ? half_r ^ posc_tick : 1'b0;
	assign half_rate_clock_out = half_r;
	assign posc_power_en = !sleep_active
		|| cfg.primary_osc_keepalive;

	// ==========================================================
	// reference clock output
	// ==========================================================
	logic        base_r, base_nxt;
	logic        base_prev_r;
	logic [14:0] rcnt_r, rcnt_nxt;
	logic [3:0]  div_act_r, div_act_nxt;
	logic        refout_pin_r, refout_pin_nxt;
	logic        ref_run;
	logic        sleep_ok;

	// sleep operation also needs the oscillator itself kept alive
	assign sleep_ok = ref_r.run_in_sleep && ref_r.source_select
		&& primary_mode && cfg.primary_osc_keepalive;
	assign ref_run  = ref_r.enable
		&& (!sleep_active || sleep_ok);
	assign base_nxt = ref_r.source_select ? posc_clk : sys_clk;

	always_comb begin
		rcnt_nxt    = rcnt_r;
		div_act_nxt = div_act_r;
		refout_pin_nxt    = 1'b0;
		if (!ref_run) begin
			rcnt_nxt    = '0;
			div_act_nxt = ref_r.divisor;
		end else begin
			if (base_r && !base_prev_r)
				rcnt_nxt = rcnt_r + 15'h0001;
			if (div_act_r == 4'h0)
				refout_pin_nxt = base_r;
			else
				refout_pin_nxt = rcnt_nxt[div_act_r - 4'h1];
			// a new divisor is taken only where a low phase begins, so no
			// short pulse reaches the pin; the count restarts from zero
			if (!refout_pin_nxt && div_act_r != ref_r.divisor
				&& (rcnt_nxt & ((15'h0001 << div_act_r)
				- 15'h0001)) == 15'h0000) begin
				div_act_nxt = ref_r.divisor;
				rcnt_nxt    = '0;
				refout_pin_nxt    = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_r      <= 1'b0;
			base_prev_r <= 1'b0;
			rcnt_r      <= '0;
			div_act_r   <= 4'h0;
			refout_pin_r      <= 1'b0;
			half_r      <= 1'b0;
		end else begin
			base_r      <= base_nxt;
			base_prev_r <= base_r;
			rcnt_r      <= rcnt_nxt;
			div_act_r   <= div_act_nxt;
			refout_pin_r      <= refout_pin_nxt;
			half_r      <= half_nxt;
		end
	end

	assign refout_pin      = refout_pin_r;
	assign refout_pin_oe_n = !ref_r.enable;

	assign status_w = {27'h0, usb_cfg_error, posc_power_en,
		div_act_r == ref_r.divisor, ref_run, usb_clk_valid};

endmodule

// ---- logic/uclk_pkg.sv ----
package uclk_pkg;

	// ==========================================================
	// register map (byte addresses on the axi4-lite slave)
	// ==========================================================
	localparam logic [3:0]  UCLK_OFS_REFCON  = 4'h0;
	localparam logic [3:0]  UCLK_OFS_CONFIG  = 4'h4;
	localparam logic [3:0]  UCLK_OFS_STATUS  = 4'h8;

	// reference_clock_control layout
	localparam int          UCLK_REF_EN_BIT   = 15;
	localparam int          UCLK_REF_SLP_BIT  = 13;
	localparam int          UCLK_REF_SEL_BIT  = 12;
	localparam int          UCLK_REF_DIV_LSB  = 8;
	localparam logic [15:0] UCLK_REF_WMASK    = 16'hbf00;
	localparam logic [15:0] UCLK_REF_RESET    = 16'h0000;

	// configuration register layout
	localparam int          UCLK_CFG_PRE_LSB  = 0;
	localparam int          UCLK_CFG_CPD_LSB  = 4;
	localparam int          UCLK_CFG_MODE_LSB = 8;
	localparam int          UCLK_CFG_KEEP_BIT = 12;
	localparam logic [31:0] UCLK_CFG_WMASK    = 32'h0000_1737;
	localparam logic [31:0] UCLK_CFG_RESET    = 32'h0000_0000;

	// oscillator modes
	localparam logic [2:0]  UCLK_MODE_RC      = 3'h0;
	localparam logic [2:0]  UCLK_MODE_RC_PLL  = 3'h1;
	localparam logic [2:0]  UCLK_MODE_XT      = 3'h2;
	localparam logic [2:0]  UCLK_MODE_HS      = 3'h3;
	localparam logic [2:0]  UCLK_MODE_EC      = 3'h4;
	localparam logic [2:0]  UCLK_MODE_XT_PLL  = 3'h5;
	localparam logic [2:0]  UCLK_MODE_HS_PLL  = 3'h6;
	localparam logic [2:0]  UCLK_MODE_EC_PLL  = 3'h7;

	// fixed branch dividers
	localparam logic [3:0]  UCLK_USB_DIV      = 4'h2;
	localparam logic [3:0]  UCLK_SYS_DIV      = 4'h3;

	// axi responses
	localparam logic [1:0]  UCLK_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  UCLK_RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic       enable;
		logic       unused14;
		logic       run_in_sleep;
		logic       source_select;
		logic [3:0] divisor;
		logic [7:0] unused_low;
	} uclk_refcon_t;

	typedef struct packed {
		logic [2:0] pll_input_prescale;
		logic [1:0] sys_clk_branch_div;
		logic [2:0] osc_mode;
		logic       primary_osc_keepalive;
	} uclk_cfg_t;

endpackage

// ---- logic/uclk_div.sv ----
module uclk_div
	import uclk_pkg::*;
#(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// tick in, tick out
	input  wire logic         tick_in,
	input  wire logic [W-1:0] div,
	output logic              tick_out
);

	// ==========================================================
	// ratio counter
	// ==========================================================
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_r;
	logic         tick_nxt;

	initial begin
		if (W < 2)
			$error("uclk_div: W must be at least 2");
	end

	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (tick_in) begin
			// a divide of zero is served as a divide of one
			if (cnt_r + W'(1) >= div) begin
				cnt_nxt  = '0;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_out = tick_r;

endmodule

// ---- sim/uclk_top_monitor.sv ----
// ==========================================================
// port checker for the clock generator
// ==========================================================
module uclk_top_monitor
	import uclk_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// sources and context
	input  wire logic pll_out_tick,
	input  wire logic posc_tick,
	input  wire logic usb_module_en,
	input  wire logic sleep_active,
	// generated outputs
	input  wire logic usb_clk_tick,
	input  wire logic sys_clk_tick,
	input  wire logic usb_clk_valid,
	input  wire logic posc_power_en,
	input  wire logic half_rate_clock_out,
	input  wire logic refout_pin,
	input  wire logic refout_pin_oe_n
);
	logic [2:0] usb_gap_r, usb_gap_nxt, sys_gap_r, sys_gap_nxt;

	// pll ticks since the last visible output tick; gating only removes ticks
	always_comb begin
		usb_gap_nxt = usb_clk_tick ? 3'h0 : usb_gap_r;
		sys_gap_nxt = sys_clk_tick ? 3'h0 : sys_gap_r;
		if (pll_out_tick && usb_gap_nxt < 3'h7)
			usb_gap_nxt = usb_gap_nxt + 3'h1;
		if (pll_out_tick && sys_gap_nxt < 3'h7)
			sys_gap_nxt = sys_gap_nxt + 3'h1;
	end

	always_ff @(posedge aclk) begin
		usb_gap_r <= aresetn ? usb_gap_nxt : 3'h0;
		sys_gap_r <= aresetn ? sys_gap_nxt : 3'h0;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	usb_gap_a: assert property (usb_clk_tick |-> usb_gap_r >= 3'h2)
		else $error("usb tick too soon");
	sys_gap_a: assert property (sys_clk_tick |-> sys_gap_r >= 3'h3)
		else $error("system tick too soon");
	usb_gate_a: assert property (usb_clk_tick |-> usb_clk_valid)
		else $error("usb tick without valid clock");
	usb_off_a: assert property (!usb_module_en |-> !usb_clk_valid)
		else $error("usb clock valid with module off");
	osc_awake_a: assert property (!sleep_active |-> posc_power_en)
		else $error("oscillator off while awake");
	ref_off_a: assert property (
		refout_pin_oe_n && $past(refout_pin_oe_n) |-> !refout_pin)
		else $error("reference pin high while disabled");
	sleep_low_a: assert property (
		(sleep_active && !posc_power_en) [*2] |-> !refout_pin)
		else $error("reference pin high in sleep");
	half_tick_a: assert property (
		$rose(half_rate_clock_out) |-> $past(posc_tick))
		else $error("half-rate rise without tick");
	reset_ref_a: assert property (disable iff (1'b0)
		$rose(aresetn) |-> refout_pin_oe_n && !refout_pin)
		else $error("reference output active after reset");

	usb_run_c: cover property (usb_clk_tick);
	ref_rise_c: cover property (!refout_pin_oe_n && $rose(refout_pin));
	sleep_run_c: cover property (sleep_active && $rose(refout_pin));
endmodule

bind uclk_top uclk_top_monitor uclk_top_monitor_i (.aclk, .aresetn,
	.pll_out_tick, .posc_tick, .usb_module_en, .sleep_active,
	.usb_clk_tick, .sys_clk_tick, .usb_clk_valid, .posc_power_en,
	.half_rate_clock_out, .refout_pin, .refout_pin_oe_n);

// ---- sim/uclk_ref_sink.sv ----
// ==========================================================
// external device clocked from the reference pin
// ==========================================================
module uclk_ref_sink (
	// sampling clock
	input  wire logic aclk,
	// reference pin
	input  wire logic refout_pin,
	input  wire logic refout_pin_oe_n,
	// period in aclk cycles and rising edge count
	output int        period,
	output int        rises
);
	timeunit 1ns;
	timeprecision 1ns;

	logic prev_r = 1'b0;
	int   since_r = 0;

	initial begin
		period = 0;
		rises = 0;
	end

	// a released pin carries no clock, so only driven edges count
	always @(posedge aclk) begin
		prev_r <= refout_pin;
		since_r <= since_r + 1;
		if (!refout_pin_oe_n && refout_pin && !prev_r) begin
			period <= since_r;
			since_r <= 1;
			rises <= rises + 1;
		end
	end
endmodule

// ---- sim/uclk_top_test.sv ----
// ==========================================================
// clock generator bench
// ==========================================================
module uclk_top_test
	import uclk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int PRE_DIV [8] = '{1, 2, 3, 4, 5, 6, 10, 12};
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, posc_tick;
	logic        pll_out_tick, posc_clk, sys_clk, sleep_active, h_prev;
	logic        usb_module_en, pll_ref_tick, usb_clk_tick, sys_clk_tick;
	logic        usb_clk_valid, posc_power_en, half_rate_clock_out;
	logic        refout_pin, refout_pin_oe_n;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          errors, cmp_count, cycles, period, rises, r0;
	int          c_ref, c_usb, c_sys, c_half;

	uclk_top uclk_top_i (.*);
	uclk_ref_sink uclk_ref_sink_i (.aclk, .refout_pin, .refout_pin_oe_n,
		.period, .rises);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// oscillator level period 4 cycles, system clock level period 6
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		posc_clk <= cycles[1];
		sys_clk <= (cycles % 6) >= 3;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	task automatic results;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input int exp, input int tol);
		cmp_count++;
		if (^got === 1'bx || got + tol < exp || got > exp + tol) begin
			errors++;
			$display("Error %0t: got %0d want %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int t;
		t = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && t < 50);
		s_axi_bready <= 1'b0;
		chk(t < 50, 1, 0);
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] e,
			input logic [1:0] er);
		int t;
		t = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && t < 50);
		s_axi_rready <= 1'b0;
		cmp_count++;
		if (s_axi_rdata !== e || s_axi_rresp !== er || t == 50) begin
			errors++;
			$display("Error %0t: read %h got %h", $time, a, s_axi_rdata);
		end
	endtask

	task automatic cfg(input logic [2:0] p, input logic [1:0] c,
			input logic [2:0] m, input logic k);
		wr({28'h0, UCLK_OFS_CONFIG}, {19'h0, k, 1'b0, m, 2'h0, c, 1'b0, p});
	endtask

	task automatic refc(input logic en, input logic slp, input logic sel,
			input logic [3:0] dv);
		wr({28'h0, UCLK_OFS_REFCON}, {16'h0, en, 1'b0, slp, sel, dv, 8'h0});
	endtask

	task automatic span(input int n);
		r0 = rises;
		{c_ref, c_usb, c_sys, c_half} = '0;
		repeat (n) begin
			@(posedge aclk);
			c_ref += pll_ref_tick;
			c_usb += usb_clk_tick;
			c_sys += sys_clk_tick;
			c_half += (half_rate_clock_out !== h_prev);
			h_prev = half_rate_clock_out;
		end
		r0 = rises - r0;
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, sleep_active, usb_module_en} = 4'h0;
		{posc_tick, pll_out_tick, posc_clk, sys_clk, h_prev} = 5'h18;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hf;
		{errors, cmp_count, cycles} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdchk({28'h0, UCLK_OFS_REFCON}, 32'h0, UCLK_RESP_OKAY);
		chk(refout_pin_oe_n, 1, 0);
		wr({28'h0, UCLK_OFS_REFCON}, 32'hffff_ffff);
		rdchk({28'h0, UCLK_OFS_REFCON}, 32'hbf00, UCLK_RESP_OKAY);
		chk(refout_pin_oe_n, 0, 0);
		refc(1'b0, 1'b0, 1'b0, 4'h0);
		span(2);
		chk(refout_pin, 0, 0);
		chk(refout_pin_oe_n, 1, 0);
		rdchk(32'h10, 32'h0, UCLK_RESP_SLVERR);
		for (int i = 0; i < 8; i++) begin
			cfg(i[2:0], 2'h0, UCLK_MODE_XT_PLL, 1'b0);
			span(20);
			span(600);
			chk(c_ref, 600 / PRE_DIV[i], 1);
		end
		for (int i = 0; i < 4; i++) begin
			usb_module_en <= (i < 2);
			cfg(3'h0, i[1:0], UCLK_MODE_HS_PLL, 1'b0);
			span(24);
			span(480);
			chk(c_sys, 160 >> i, 1);
			chk(c_usb, (i < 2) ? 240 : 0, 1);
		end
		usb_module_en <= 1'b1;
		cfg(3'h0, 2'h0, UCLK_MODE_XT, 1'b0);
		span(50);
		chk(c_usb, 0, 0);
		chk(c_half, 0, 0);
		usb_module_en <= 1'b0;
		cfg(3'h1, 2'h0, UCLK_MODE_RC_PLL, 1'b0);
		span(50);
		chk(c_half, 50, 2);
		for (int s = 0; s < 2; s++) begin
			for (int n = 0; n < 4; n++) begin
				refc(1'b1, 1'b0, s[0], n[3:0]);
				span(600);
				chk(period, (s ? 4 : 6) << n, 0);
			end
		end
		cfg(3'h0, 2'h0, UCLK_MODE_XT, 1'b1);
		refc(1'b1, 1'b1, 1'b1, 4'h0);
		sleep_active <= 1'b1;
		span(40);
		span(100);
		chk(r0, 25, 1);
		refc(1'b1, 1'b0, 1'b1, 4'h0);
		span(100);
		chk(r0, 0, 0);
		cfg(3'h0, 2'h0, UCLK_MODE_XT, 1'b0);
		chk(posc_power_en, 0, 0);
		sleep_active <= 1'b0;
		span(2);
		chk(posc_power_en, 1, 0);
		results();
	end
endmodule
